// ==== hw/lsod_defs.svh ====
// constants of the led scan timing and open detect block
// assumes a 32-bit axi4-lite register port and byte addresses
`ifndef LSOD_DEFS_SVH
`define LSOD_DEFS_SVH
// ***********************
// register byte offsets
// ***********************
`define LSOD_OFF_GAIN    8'h00
`define LSOD_OFF_CLKCFG  8'h04
`define LSOD_OFF_SCANCFG 8'h08
`define LSOD_OFF_THRESH  8'h0c
`define LSOD_OFF_STATUS  8'h10
`define LSOD_OFF_MASK    8'h14
`define LSOD_OFF_STATE   8'h18
`define LSOD_OFF_OPEN_LO 8'h1c
`define LSOD_OFF_OPEN_HI 8'h20
`define LSOD_OFF_LINEREC 8'h24
// ***********************
// reset values and fields
// ***********************
`define LSOD_GAIN_RST    24'h7f7f7f
`define LSOD_CLK_RST     7'h00
`define LSOD_SCAN_RST    9'h000
`define LSOD_THR_RST     12'h000
`define LSOD_EVT_OTP     0
`define LSOD_EVT_REF     1
`define LSOD_EVT_OPEN    2
`define LSOD_EVT_SEG     3
`define LSOD_RB_BIT      4
// ***********************
// transition counts and bus answers
// ***********************
`define LSOD_SW_BASE     9'd45
`define LSOD_SW_STEP     9'd30
`define LSOD_RESP_OKAY   2'b00
`define LSOD_RESP_SLVERR 2'b10
`endif

// ==== hw/lsod_pkg.sv ====
// types of the led scan timing and open detect block
// assumes lsod_defs.svh for all numeric constants
package lsod_pkg;
  typedef struct packed {
    logic [7:0] blue_group_gain_code;
    logic [7:0] green_group_gain_code;
    logic [7:0] red_group_gain_code;
  } lsod_gain_s;
  typedef struct packed {
    logic       halving_bypass_bit;
    logic [3:0] multiplier_factor_field;
    logic [1:0] multiplier_mode_field;
  } lsod_clk_s;
  typedef struct packed {
    logic [3:0] blue_open_threshold;
    logic [3:0] green_open_threshold;
    logic [3:0] red_open_threshold;
  } lsod_thr_s;
  typedef struct packed {
    logic [3:0] last_line;
    logic       fault_readback_enable;
    logic [3:0] line_switch_time_code;
  } lsod_scan_s;
  typedef enum logic [2:0] {SEQ_PWM, SEQ_T0, SEQ_T1, SEQ_T2, SEQ_T3} lsod_seq_e;
endpackage

// ==== hw/lsod_top.sv ====
// scan line transition sequencer, gain and clock setup, protection and open detect
// assumes grayscale_clock_tick is a one-cycle grayscale clock enable and all inputs are synchronous
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "lsod_defs.svh"

// Contract
// RULE1: three 8-bit gain codes, one per 16-channel colour group, scale the group in 256 steps.
// RULE2: each group current is the maximum set current times code plus one over 256.
// RULE3: the grayscale clock comes from the serial clock via multiplier mode and factor fields.
// RULE4: the halving bypass bit is 0 up to 80 MHz and 1 above it.
// RULE5: between segments four ordered intervals run: pwm end, pre-discharge, line off, line on.
// RULE6: a 4-bit line switch time code sets the total of the four intervals.
// RULE7: code 0 gives 45 grayscale clocks, code 1 gives 60, each step adds 30 up to 480.
// RULE8: while over-temperature cutoff is active every channel output is off.
// RULE9: while the reference resistor pin is low all channels are off, with hysteresis.
// RULE10: a channel open bit is 1 when its voltage exceeds its group threshold, else 0.
// RULE11: open comparator results count only while that channel output is on.
// RULE12: at segment end the open bits latch into a 48-bit word and the line is recorded.
// RULE13: software enables fault readback before it reads open fault information.
// RULE14: software waits one sub-period between the second and third read steps.
// RULE15: either protection alone forces all channels off; both must clear to restore.
module lsod_top
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        grayscale_clock_tick,
  input  wire logic        pwm_done,
  input  wire logic [47:0] pwm_active,
  input  wire logic [47:0] open_compare,
  input  wire logic        over_temp_enter,
  input  wire logic        over_temp_exit,
  input  wire logic        ref_short_enter,
  input  wire logic        ref_short_exit,
  output logic [47:0]      channel_output,
  output logic [8:0]       red_scale,
  output logic [8:0]       green_scale,
  output logic [8:0]       blue_scale,
  output lsod_pkg::lsod_clk_s clk_setup,
  output lsod_pkg::lsod_thr_s open_thresholds,
  output logic [3:0]       scan_line,
  output logic             line_on,
  output logic             pre_discharge,
  output logic             segment_start,
  output logic             irq
);
  // ***********************
  // functions
  // ***********************
  function automatic logic [8:0] sw_total(input logic [3:0] code);
    if (code == 4'h0)
      sw_total = `LSOD_SW_BASE; // RULE7
    else
      sw_total = 9'(({5'h00, code} + 9'h001) * `LSOD_SW_STEP); // RULE7
  endfunction
  function automatic logic [8:0] scale_of(input logic [7:0] code);
    scale_of = {1'b0, code} + 9'h001; // RULE2
  endfunction
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  be);
    be_merge = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        be_merge[i*8 +: 8] = dat[i*8 +: 8];
  endfunction
  // ***********************
  // state
  // ***********************
  lsod_pkg::lsod_gain_s gain_r;
  lsod_pkg::lsod_clk_s  clk_r;
  lsod_pkg::lsod_scan_s scan_r;
  lsod_pkg::lsod_thr_s  thr_r;
  lsod_pkg::lsod_seq_e  seq_r;
  lsod_pkg::lsod_seq_e  seq_nxt;
  logic [3:0]  status_r;
  logic [3:0]  mask_r;
  logic        otp_r;
  logic        refs_r;
  logic [47:0] open_acc_r;
  logic [47:0] open_word_r;
  logic [15:0] line_rec_r;
  logic [8:0]  cnt_r;
  logic [3:0]  line_r;
  logic        aw_full_r;
  logic        w_full_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  // ***********************
  // sequencer decode
  // ***********************
  wire [8:0] tsw       = sw_total(scan_r.line_switch_time_code); // RULE6
  wire [8:0] quarter   = {2'b00, tsw[8:2]};
  wire [8:0] last_part = 9'(tsw - quarter - quarter - quarter);
  wire [8:0] bound     = (seq_r == lsod_pkg::SEQ_T3) ? last_part : quarter;
  wire       int_done  = grayscale_clock_tick && (cnt_r == 9'(bound - 9'h001));
  wire       seg_end   = (seq_r == lsod_pkg::SEQ_PWM) && pwm_done;
  wire       prot      = otp_r || refs_r; // RULE15
  wire [3:0] line_next = (line_r == scan_r.last_line) ? 4'h0 : 4'(line_r + 4'h1);
  wire [47:0] open_hit = open_compare & channel_output; // RULE11
  wire       ch_off    = prot || (seq_nxt != lsod_pkg::SEQ_PWM); // RULE8 RULE9 RULE15
  always_comb
  begin
    seq_nxt = seq_r;
    unique case (seq_r)
      lsod_pkg::SEQ_PWM: if (seg_end) seq_nxt = lsod_pkg::SEQ_T0; // RULE5
      lsod_pkg::SEQ_T0:  if (int_done) seq_nxt = lsod_pkg::SEQ_T1; // RULE5
      lsod_pkg::SEQ_T1:  if (int_done) seq_nxt = lsod_pkg::SEQ_T2; // RULE5
      lsod_pkg::SEQ_T2:  if (int_done) seq_nxt = lsod_pkg::SEQ_T3; // RULE5
      lsod_pkg::SEQ_T3:  if (int_done) seq_nxt = lsod_pkg::SEQ_PWM; // RULE5
    endcase
  end
  // ***********************
  // bus decode
  // ***********************
  wire        do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  wire        wr_gain  = do_write && (awaddr_r == `LSOD_OFF_GAIN);
  wire        wr_clk   = do_write && (awaddr_r == `LSOD_OFF_CLKCFG);
  wire        wr_scan  = do_write && (awaddr_r == `LSOD_OFF_SCANCFG);
  wire        wr_thr   = do_write && (awaddr_r == `LSOD_OFF_THRESH);
  wire        wr_mask  = do_write && (awaddr_r == `LSOD_OFF_MASK);
  wire        wr_ok    = wr_gain || wr_clk || wr_scan || wr_thr || wr_mask ||
                         (awaddr_r == `LSOD_OFF_STATUS) || (awaddr_r == `LSOD_OFF_STATE) ||
                         (awaddr_r == `LSOD_OFF_OPEN_LO) || (awaddr_r == `LSOD_OFF_OPEN_HI) ||
                         (awaddr_r == `LSOD_OFF_LINEREC);
  wire        do_read  = s_axi_arvalid && !s_axi_rvalid;
  wire        rd_stat  = do_read && (s_axi_araddr == `LSOD_OFF_STATUS);
  wire        rb_en    = scan_r.fault_readback_enable; // RULE13
  wire [31:0] wmerge   = be_merge(32'h0000_0000, wdata_r, wstrb_r);
  wire [31:0] gain_w   = be_merge({8'h00, gain_r}, wdata_r, wstrb_r);
  wire [31:0] clk_w    = be_merge({25'h0, clk_r}, wdata_r, wstrb_r);
  wire [31:0] scan_w   = be_merge({20'h0, scan_r.last_line, 3'h0,
                                   scan_r.fault_readback_enable,
                                   scan_r.line_switch_time_code}, wdata_r, wstrb_r);
  wire [31:0] thr_w    = be_merge({20'h0, thr_r}, wdata_r, wstrb_r);
  wire [3:0]  events   = {seg_end, seg_end && (open_acc_r != 48'h0),
                          ref_short_enter && !refs_r, over_temp_enter && !otp_r};
  logic [31:0] rmux;
  logic        rhit;
  always_comb
  begin
    rhit = 1'b1;
    unique case (s_axi_araddr)
      `LSOD_OFF_GAIN:    rmux = {8'h00, gain_r};
      `LSOD_OFF_CLKCFG:  rmux = {25'h0, clk_r};
      `LSOD_OFF_SCANCFG: rmux = {20'h0, scan_r.last_line, 3'h0,
                                 scan_r.fault_readback_enable, scan_r.line_switch_time_code};
      `LSOD_OFF_THRESH:  rmux = {20'h0, thr_r};
      `LSOD_OFF_STATUS:  rmux = {28'h0, status_r};
      `LSOD_OFF_MASK:    rmux = {28'h0, mask_r};
      `LSOD_OFF_STATE:   rmux = {20'h0, line_r, 3'h0, seq_r, refs_r, otp_r};
      `LSOD_OFF_OPEN_LO: rmux = rb_en ? open_word_r[31:0] : 32'h0; // RULE13
      `LSOD_OFF_OPEN_HI: rmux = rb_en ? {16'h0, open_word_r[47:32]} : 32'h0; // RULE13
      `LSOD_OFF_LINEREC: rmux = rb_en ? {16'h0, line_rec_r} : 32'h0; // RULE13
      default:
      begin
        rmux = 32'h0;
        rhit = 1'b0;
      end
    endcase
  end
  // ***********************
  // axi4-lite slave
  // ***********************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LSOD_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `LSOD_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_full_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_full_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `LSOD_RESP_OKAY : `LSOD_RESP_SLVERR;
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= do_read;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux;
        s_axi_rresp  <= rhit ? `LSOD_RESP_OKAY : `LSOD_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  // ***********************
  // configuration registers
  // ***********************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_r <= `LSOD_GAIN_RST;
      clk_r  <= `LSOD_CLK_RST;
      scan_r <= `LSOD_SCAN_RST;
      thr_r  <= `LSOD_THR_RST;
      mask_r <= 4'h0;
    end
    else
    begin
      if (wr_gain)
        gain_r <= gain_w[23:0]; // RULE1
      if (wr_clk)
        clk_r <= clk_w[6:0]; // RULE3 RULE4
      if (wr_scan)
        scan_r <= {scan_w[11:8], scan_w[4:0]}; // RULE6
      if (wr_thr)
        thr_r <= thr_w[11:0]; // RULE10
      if (wr_mask)
        mask_r <= wmerge[3:0];
    end
  end
  // ***********************
  // status, protection and interrupt
  // ***********************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_r <= 4'h0;
      otp_r    <= 1'b0;
      refs_r   <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      status_r <= (rd_stat ? 4'h0 : status_r) | events;
      if (over_temp_enter)
        otp_r <= 1'b1; // RULE8
      else if (over_temp_exit)
        otp_r <= 1'b0; // RULE8
      if (ref_short_enter)
        refs_r <= 1'b1; // RULE9
      else if (ref_short_exit)
        refs_r <= 1'b0; // RULE9
      irq <= |(((rd_stat ? 4'h0 : status_r) | events) & mask_r);
    end
  end
  // ***********************
  // line transition sequencer
  // ***********************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_r         <= lsod_pkg::SEQ_PWM;
      cnt_r         <= 9'h000;
      line_r        <= 4'h0;
      line_on       <= 1'b1;
      pre_discharge <= 1'b0;
      segment_start <= 1'b0;
      scan_line     <= 4'h0;
    end
    else
    begin
      seq_r         <= seq_nxt;
      segment_start <= (seq_r == lsod_pkg::SEQ_T3) && int_done; // RULE5
      if (seq_nxt != seq_r)
        cnt_r <= 9'h000;
      else if (grayscale_clock_tick && (seq_r != lsod_pkg::SEQ_PWM))
        cnt_r <= 9'(cnt_r + 9'h001); // RULE6
      if ((seq_r == lsod_pkg::SEQ_T0) && int_done)
        pre_discharge <= 1'b1; // RULE5
      if ((seq_r == lsod_pkg::SEQ_T1) && int_done)
        line_on <= 1'b0; // RULE5
      if ((seq_r == lsod_pkg::SEQ_T2) && int_done)
      begin
        line_r        <= line_next; // RULE5
        scan_line     <= line_next; // RULE5
        line_on       <= 1'b1;
        pre_discharge <= 1'b0;
      end
    end
  end
  // ***********************
  // channels, open detect, gain and clock outputs
  // ***********************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_output <= 48'h0;
      open_acc_r     <= 48'h0;
      open_word_r    <= 48'h0;
      line_rec_r     <= 16'h0;
    end
    else
    begin
      channel_output <= ch_off ? 48'h0 : pwm_active; // RULE8 RULE9 RULE15
      if (seg_end)
      begin
        open_word_r <= open_acc_r | open_hit; // RULE12 RULE10
        open_acc_r  <= 48'h0;
        if ((open_acc_r | open_hit) != 48'h0)
          line_rec_r[line_r] <= 1'b1; // RULE12
      end
      else
        open_acc_r <= open_acc_r | open_hit; // RULE10 RULE11
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      red_scale       <= 9'h000;
      green_scale     <= 9'h000;
      blue_scale      <= 9'h000;
      clk_setup       <= `LSOD_CLK_RST;
      open_thresholds <= `LSOD_THR_RST;
    end
    else
    begin
      red_scale       <= scale_of(gain_r.red_group_gain_code); // RULE1 RULE2
      green_scale     <= scale_of(gain_r.green_group_gain_code); // RULE1 RULE2
      blue_scale      <= scale_of(gain_r.blue_group_gain_code); // RULE1 RULE2
      clk_setup       <= clk_r; // RULE3 RULE4
      open_thresholds <= thr_r; // RULE10
    end
  end
endmodule

// ==== test/lsod_led_model.sv ====
// led matrix model: grayscale clock ticks and per-channel open comparators
// assumes channel_output from lsod_top, fault_mask chosen by the bench
`timescale 1ns/1ns
module lsod_led_model
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        slow,
  input wire logic [47:0] fault_mask,
  input wire logic [47:0] channel_output,
  output logic            grayscale_clock_tick,
  output logic [47:0]     open_compare
);
  logic        ph_r;
  logic [47:0] junk_r;
  always_ff @(posedge aclk)
  begin
    ph_r   <= aresetn ? ~ph_r : 1'b0;
    junk_r <= aresetn ? ~junk_r : 48'h5555_5555_5555;
  end
  // ticks every cycle, or every other cycle when slow
  assign grayscale_clock_tick    = aresetn && (!slow || ph_r);
  // unlit channels show a changing pattern
  assign open_compare = (channel_output & fault_mask) | (~channel_output & junk_r);
endmodule

// ==== test/lsod_top_sva.sv ====
// checker for the scan sequencer, protection gating and gain outputs
// assumes the ports of lsod_top and one clock domain on aclk
`timescale 1ns/1ns
module lsod_top_sva
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [47:0] pwm_active,
  input wire logic        over_temp_enter,
  input wire logic        ref_short_enter,
  input wire logic [47:0] channel_output,
  input wire logic [8:0]  red_scale,
  input wire logic [8:0]  green_scale,
  input wire logic [8:0]  blue_scale,
  input wire logic [3:0]  scan_line,
  input wire logic        line_on,
  input wire logic        pre_discharge,
  input wire logic        segment_start
);
  // ***********************
  // properties
  // ***********************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_dark;
    channel_output == 48'h0;
  endsequence
  sequence s_idle;
    line_on && !pre_discharge;
  endsequence
  property p_otp;
    over_temp_enter |-> ##2 s_dark;
  endproperty
  property p_ref;
    ref_short_enter |-> ##2 s_dark;
  endproperty
  property p_gate;
    (channel_output & ~$past(pwm_active)) == 48'h0;
  endproperty
  property p_pre;
    $rose(pre_discharge) |-> line_on and s_dark;
  endproperty
  property p_off;
    $fell(line_on) |-> pre_discharge and s_dark;
  endproperty
  property p_on;
    $rose(line_on) |-> !pre_discharge && scan_line != $past(scan_line);
  endproperty
  property p_seg;
    segment_start |-> s_idle ##1 !segment_start;
  endproperty
  property p_scale;
    $past(aresetn) |-> red_scale inside {[1:256]} && green_scale inside {[1:256]}
      && blue_scale inside {[1:256]};
  endproperty
  a_otp: assert property (p_otp) else $error("outputs on after over-temperature");
  a_ref: assert property (p_ref) else $error("outputs on after reference short");
  a_gate: assert property (p_gate) else $error("output on without pwm request");
  a_pre: assert property (p_pre) else $error("pre-discharge out of order");
  a_off: assert property (p_off) else $error("line off out of order");
  a_on: assert property (p_on) else $error("next line on without line change");
  a_seg: assert property (p_seg) else $error("segment start malformed");
  a_scale: assert property (p_scale) else $error("gain scale out of range");
endmodule
bind lsod_top lsod_top_sva lsod_top_sva_inst (.aclk, .aresetn, .pwm_active, .over_temp_enter,
  .ref_short_enter, .channel_output, .red_scale, .green_scale, .blue_scale, .scan_line,
  .line_on, .pre_discharge, .segment_start);

// ==== test/tb_top.sv ====
// testbench: register, sequencer, open detect and protection tests
// assumes lsod_top with an axi4-lite slave and the led matrix model
`timescale 1ns/1ns
`include "lsod_defs.svh"
`define TB_CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, grayscale_clock_tick, pwm_done, over_temp_enter, over_temp_exit, slow;
  logic ref_short_enter, ref_short_exit, line_on, pre_discharge, segment_start, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb, scan_line, exp_line;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [47:0] pwm_active, open_compare, channel_output, fault_mask;
  logic [8:0] red_scale, green_scale, blue_scale;
  lsod_pkg::lsod_clk_s clk_setup;
  lsod_pkg::lsod_thr_s open_thresholds;
  int n_mismatch = 0;
  int cmp_count = 0;
  int dur[3];
  logic [3:0] codes[3] = '{4'h0, 4'h1, 4'hf};
  lsod_top lsod_top_inst (.*);
  lsod_led_model lsod_led_model_inst (.*);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ***********************
  // tasks
  // ***********************
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (n < 200 && !s_axi_bvalid)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (n >= 200) begin n_mismatch++; conclude(); end
    `TB_CHK(s_axi_bresp, `LSOD_RESP_OKAY)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    while (n < 200 && !s_axi_rvalid)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (n >= 200) begin n_mismatch++; conclude(); end
    {d, r} = {s_axi_rdata, s_axi_rresp};
  endtask
  task automatic seg(output int c);
    @(posedge aclk);
    pwm_done <= 1'b1;
    @(posedge aclk);
    pwm_done <= 1'b0;
    c = 1;
    while (!segment_start && c < 2000)
    begin
      @(posedge aclk);
      c++;
    end
    if (c >= 2000) begin n_mismatch++; conclude(); end
    exp_line = exp_line ^ 4'h1;
  endtask
  // ***********************
  // tests
  // ***********************
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {pwm_done, over_temp_enter, over_temp_exit, ref_short_enter, ref_short_exit} = 5'h0;
    {pwm_active, fault_mask, slow, exp_line} = {48'h0, 48'h0100_0000_0008, 1'b1, 4'h0};
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    rd(`LSOD_OFF_GAIN, rv, rs);
    `TB_CHK(rv, {8'h00, `LSOD_GAIN_RST})
    `TB_CHK(red_scale, 9'h080)
    rd(8'h28, rv, rs);
    `TB_CHK({rs, rv}, {`LSOD_RESP_SLVERR, 32'h0})
    wr(`LSOD_OFF_GAIN, 32'h00ff0100);
    tick(3);
    `TB_CHK({red_scale, green_scale, blue_scale}, {9'h001, 9'h002, 9'h100})
    wr(`LSOD_OFF_CLKCFG, 32'h55);
    tick(2);
    `TB_CHK(clk_setup, 7'h55)
    rd(`LSOD_OFF_CLKCFG, rv, rs);
    `TB_CHK(rv, 32'h55)
    wr(`LSOD_OFF_THRESH, 32'habc);
    tick(2);
    `TB_CHK(open_thresholds, 12'habc)
    $display("test config done");
    wr(`LSOD_OFF_SCANCFG, 32'h100);
    pwm_active <= 48'h28;
    tick(4);
    `TB_CHK(channel_output, 48'h28)
    seg(dur[0]);
    `TB_CHK(scan_line, exp_line)
    rd(`LSOD_OFF_OPEN_LO, rv, rs);
    `TB_CHK(rv, 32'h0)
    wr(`LSOD_OFF_SCANCFG, 32'h110);
    tick(100);
    rd(`LSOD_OFF_OPEN_LO, rv, rs);
    `TB_CHK(rv, 32'h8)
    rd(`LSOD_OFF_OPEN_HI, rv, rs);
    `TB_CHK(rv, 32'h0)
    rd(`LSOD_OFF_LINEREC, rv, rs);
    `TB_CHK(rv, 32'h1)
    rd(`LSOD_OFF_STATUS, rv, rs);
    `TB_CHK(rv, 32'hc)
    $display("test open detect done");
    slow <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      wr(`LSOD_OFF_SCANCFG, 32'h110 | 32'(codes[i]));
      seg(dur[i]);
      `TB_CHK(scan_line, exp_line)
    end
    `TB_CHK(dur[1] - dur[0], 15)
    `TB_CHK(dur[2] - dur[0], 435)
    $display("test line switch done");
    wr(`LSOD_OFF_MASK, 32'h3);
    rd(`LSOD_OFF_STATUS, rv, rs);
    tick(2);
    `TB_CHK(irq, 1'b0)
    over_temp_enter <= 1'b1;
    tick(1);
    over_temp_enter <= 1'b0;
    tick(3);
    `TB_CHK({irq, channel_output}, {1'b1, 48'h0})
    ref_short_enter <= 1'b1;
    tick(1);
    {ref_short_enter, over_temp_exit} <= 2'b01;
    tick(1);
    over_temp_exit <= 1'b0;
    tick(3);
    `TB_CHK(channel_output, 48'h0)
    rd(`LSOD_OFF_STATE, rv, rs);
    `TB_CHK(rv, {20'h0, exp_line, 8'h02})
    ref_short_exit <= 1'b1;
    tick(1);
    ref_short_exit <= 1'b0;
    tick(3);
    `TB_CHK(channel_output, 48'h28)
    rd(`LSOD_OFF_STATUS, rv, rs);
    `TB_CHK(rv, 32'h3)
    tick(2);
    `TB_CHK(irq, 1'b0)
    $display("test protection done");
    conclude();
  end
endmodule
